// ==== hdl/ext_port_pkg.sv ====
// package: external port bank windows, access types and request carriers
package ext_port_pkg;

    localparam int ADDR_W   = 32;
    localparam int NUM_BANK = 4;

    // asynchronous memory windows (normal-word addresses)
    localparam logic [31:0] ASYNC_B0_LO = 32'h0020_0000;
    localparam logic [31:0] ASYNC_B0_HI = 32'h007F_FFFF;
    localparam logic [31:0] ASYNC_B1_LO = 32'h0400_0000;
    localparam logic [31:0] ASYNC_B1_HI = 32'h047F_FFFF;
    localparam logic [31:0] ASYNC_B2_LO = 32'h0800_0000;
    localparam logic [31:0] ASYNC_B2_HI = 32'h087F_FFFF;
    localparam logic [31:0] ASYNC_B3_LO = 32'h0C00_0000;
    localparam logic [31:0] ASYNC_B3_HI = 32'h0C7F_FFFF;

    // synchronous dram windows
    localparam logic [31:0] SYNC_B0_LO = 32'h0020_0000;
    localparam logic [31:0] SYNC_B0_HI = 32'h03FF_FFFF;
    localparam logic [31:0] SYNC_B1_LO = 32'h0400_0000;
    localparam logic [31:0] SYNC_B1_HI = 32'h07FF_FFFF;
    localparam logic [31:0] SYNC_B2_LO = 32'h0800_0000;
    localparam logic [31:0] SYNC_B2_HI = 32'h0BFF_FFFF;
    localparam logic [31:0] SYNC_B3_LO = 32'h0C00_0000;
    localparam logic [31:0] SYNC_B3_HI = 32'h0FFF_FFFF;

    // bank 0 instruction fetch windows
    localparam logic [31:0] FETCH_BASE_LO = 32'h0020_0000;
    localparam logic [31:0] FETCH_BASE_HI = 32'h005F_FFFF;
    localparam logic [31:0] FETCH_VAR_LO  = 32'h0060_0000;
    localparam logic [31:0] FETCH_VAR_HI  = 32'h00FF_FFFF;

    // dram bank capacity code: 0 = 4M bytes .. 6 = 256M bytes
    localparam logic [2:0] DRAM_SIZE_MIN = 3'h0;
    localparam logic [2:0] DRAM_SIZE_MAX = 3'h6;

    localparam int TIME_W = 4;
    localparam logic [TIME_W-1:0] WAIT_RST = 4'h2;

    typedef enum logic [1:0] {
        ACC_DATA      = 2'h0,
        ACC_DATA_SIMD = 2'h1,
        ACC_FETCH_BASE = 2'h2,
        ACC_FETCH_VAR  = 2'h3
    } acc_kind_t;

    typedef struct packed {
        logic [31:0] addr;
        logic        write;
        acc_kind_t   kind;
        logic [31:0] wdata_x;
        logic [31:0] wdata_y;
    } ext_req_t;

    typedef struct packed {
        logic        is_sync;
        logic [2:0]  dram_size;
        logic [TIME_W-1:0] wait_cycles;
    } bank_cfg_t;

    typedef struct packed {
        logic [31:0] rdata_x;
        logic [31:0] rdata_y;
        logic        fault;
    } ext_rsp_t;

endpackage

// ==== hdl/external_port_bank_decoder.sv ====
// external port: core/dma arbitration, bank decode and memory cycle sequencing
// Functional notes
// - address space has four banks, each set to asynchronous or synchronous memory
// - async bank 0 window is 0x0020_0000 to 0x007F_FFFF
// - async banks 1-3 are 8M-word windows at 0x04, 0x08, 0x0C million bases
// - partly filled async banks keep fixed windows, never made contiguous
// - async interface keeps separate timing settings for every bank
// - dram bank 0 window is 0x0020_0000 to 0x03FF_FFFF
// - dram banks 1-3 are 64M-word windows at their fixed bases
// - one active-low select line per bank
// - each dram bank capacity configurable from 4M to 256M bytes
// - dram controller timing is programmable for slower devices
// - windows are normal-word addresses; code and data must not overlap
// - simd normal-word dram access moves secondary word on 64-bit data bus
// - instruction fetches allowed only from bank 0
// - base format fetch window is 0x0020_0000 to 0x005F_FFFF
// - compressed fetch window is 0x0060_0000 to 0x00FF_FFFF, up to three per fetch
// - arbiter serialises core and dma transfers onto the single port
`timescale 1ns/1ns
module external_port_bank_decoder
    import ext_port_pkg::*;
#(
    parameter int DATA_W = 64
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // bank configuration
    input  wire ext_port_pkg::bank_cfg_t   bank_cfg [ext_port_pkg::NUM_BANK],
    input  wire logic [ext_port_pkg::TIME_W-1:0] dram_cas_cycles,
    // core master
    input  wire logic                      core_valid,
    output logic                           core_ready,
    input  wire ext_port_pkg::ext_req_t    core_req,
    output logic                           core_done,
    // dma master
    input  wire logic                      dma_valid,
    output logic                           dma_ready,
    input  wire ext_port_pkg::ext_req_t    dma_req,
    output logic                           dma_done,
    // shared response
    output ext_port_pkg::ext_rsp_t         rsp,
    // external memory port
    output logic [ext_port_pkg::NUM_BANK-1:0] mem_bank_select_n,
    output logic [31:0]                    ext_addr,
    output logic                           ext_rd_n,
    output logic                           ext_wr_n,
    output logic                           dram_cycle,
    input  wire logic [DATA_W-1:0]         ext_port_data_in,
    output logic [DATA_W-1:0]              ext_port_data_out,
    output logic                           ext_port_data_oe
);
    import ext_port_pkg::*;

    // elaboration checks: data path and decode tables are fixed to these sizes
    if (DATA_W != 64) begin : g_chk_data_w
        $error("external port data bus must be 64 bits wide");
    end
    if (NUM_BANK != 4) begin : g_chk_banks
        $error("bank decode tables are written for four banks");
    end
    if (TIME_W < 2) begin : g_chk_time_w
        $error("wait counter too narrow for the reset wait value");
    end

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_XFER = 4'b0100,
        ST_DONE = 4'b1000
    } state_t;

    logic              rst_s1_r;
    logic              rst_sync_n;
    state_t            state_r;
    ext_req_t          cur_r;
    logic              cur_dma_r;
    logic              last_dma_r;
    logic [NUM_BANK-1:0] sel_r;
    logic              sync_r;
    logic [TIME_W-1:0] cnt_r;
    logic [NUM_BANK-1:0] hit;
    logic              grant_core;
    logic              grant_dma;
    logic              take;
    ext_req_t          win_req;
    logic [2:0]        size_cap [NUM_BANK];
    logic [31:0]       lo_a [NUM_BANK];
    logic [31:0]       hi_a [NUM_BANK];
    logic [31:0]       lo_s [NUM_BANK];
    logic [31:0]       hi_s [NUM_BANK];
    logic              fetch_ok;
    logic [31:0]       dram_top [NUM_BANK];

    // reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1_r   <= 1'b1;
            rst_sync_n <= rst_s1_r;
        end
    end

    // fixed windows per bank; not compacted when partly populated
    assign lo_a[0] = ASYNC_B0_LO;
    assign hi_a[0] = ASYNC_B0_HI;
    assign lo_a[1] = ASYNC_B1_LO;
    assign hi_a[1] = ASYNC_B1_HI;
    assign lo_a[2] = ASYNC_B2_LO;
    assign hi_a[2] = ASYNC_B2_HI;
    assign lo_a[3] = ASYNC_B3_LO;
    assign hi_a[3] = ASYNC_B3_HI;
    assign lo_s[0] = SYNC_B0_LO;
    assign hi_s[0] = SYNC_B0_HI;
    assign lo_s[1] = SYNC_B1_LO;
    assign hi_s[1] = SYNC_B1_HI;
    assign lo_s[2] = SYNC_B2_LO;
    assign hi_s[2] = SYNC_B2_HI;
    assign lo_s[3] = SYNC_B3_LO;
    assign hi_s[3] = SYNC_B3_HI;

    // arbitration: round robin between core and dma
    assign grant_core = (state_r == ST_IDLE) && core_valid && (!dma_valid || last_dma_r);
    assign grant_dma  = (state_r == ST_IDLE) && dma_valid && (!core_valid || !last_dma_r);
    assign take       = grant_core || grant_dma;
    assign win_req    = grant_dma ? dma_req : core_req;
    assign core_ready = grant_core;
    assign dma_ready  = grant_dma;

    // fetches only from bank 0 inside the format's own window
    always_comb begin
        fetch_ok = 1'b1;
        case (win_req.kind)
            ACC_FETCH_BASE: fetch_ok = (win_req.addr >= FETCH_BASE_LO)
                                    && (win_req.addr <= FETCH_BASE_HI);
            ACC_FETCH_VAR:  fetch_ok = (win_req.addr >= FETCH_VAR_LO)
                                    && (win_req.addr <= FETCH_VAR_HI);
            default:        fetch_ok = 1'b1;
        endcase
    end

    // bank decode per bank; dram banks limited to configured capacity
    genvar g;
    generate
        for (g = 0; g < NUM_BANK; g++) begin : g_bank
            // capacity in 32-bit words: 1M words << code, clamped to 256M bytes
            assign size_cap[g] = (bank_cfg[g].dram_size > DRAM_SIZE_MAX) ?
                                 DRAM_SIZE_MAX : bank_cfg[g].dram_size;
            assign dram_top[g] = lo_s[g] + ((32'h0010_0000 << size_cap[g]) - 32'h1);
            always_comb begin
                if (bank_cfg[g].is_sync) begin
                    hit[g] = (win_req.addr >= lo_s[g]) && (win_req.addr <= hi_s[g])
                          && (win_req.addr <= dram_top[g]);
                end else begin
                    hit[g] = (win_req.addr >= lo_a[g]) && (win_req.addr <= hi_a[g]);
                end
                if ((win_req.kind == ACC_FETCH_BASE || win_req.kind == ACC_FETCH_VAR)
                    && g != 0) begin
                    hit[g] = 1'b0;
                end
            end
        end
    endgenerate

    // request capture and port state
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_r    <= ST_IDLE;
            cur_r      <= '0;
            cur_dma_r  <= 1'b0;
            last_dma_r <= 1'b0;
            sel_r      <= '0;
            sync_r     <= 1'b0;
            cnt_r      <= WAIT_RST;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (take) begin
                        cur_r      <= win_req;
                        cur_dma_r  <= grant_dma;
                        last_dma_r <= grant_dma;
                        sel_r      <= fetch_ok ? hit : '0;
                        sync_r     <= 1'b0;
                        for (int i = 0; i < NUM_BANK; i++) begin
                            if (hit[i] && bank_cfg[i].is_sync) begin
                                sync_r <= 1'b1;
                            end
                        end
                        state_r <= (fetch_ok && (hit != '0)) ? ST_SETUP : ST_DONE;
                    end
                end
                ST_SETUP: begin
                    // per-bank wait for async, programmable latency for dram
                    cnt_r <= sync_r ? dram_cas_cycles : bank_cfg_wait(sel_r);
                    state_r <= ST_XFER;
                end
                ST_XFER: begin
                    if (cnt_r == '0) begin
                        state_r <= ST_DONE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ST_DONE: begin
                    sel_r   <= '0;
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    function automatic logic [TIME_W-1:0] bank_cfg_wait(input logic [NUM_BANK-1:0] s);
        logic [TIME_W-1:0] w;
        w = '0;
        for (int i = 0; i < NUM_BANK; i++) begin
            if (s[i]) begin
                w = bank_cfg[i].wait_cycles;
            end
        end
        return w;
    endfunction

    // external pins
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mem_bank_select_n <= '1;
            ext_addr          <= '0;
            ext_rd_n          <= 1'b1;
            ext_wr_n          <= 1'b1;
            dram_cycle        <= 1'b0;
            ext_port_data_out <= '0;
            ext_port_data_oe  <= 1'b0;
        end else begin
            if (state_r == ST_SETUP) begin
                mem_bank_select_n <= ~sel_r;
                ext_addr          <= cur_r.addr;
                ext_rd_n          <= cur_r.write;
                ext_wr_n          <= ~cur_r.write;
                dram_cycle        <= sync_r;
                ext_port_data_oe  <= cur_r.write;
                ext_port_data_out <= {(sync_r && cur_r.kind == ACC_DATA_SIMD) ?
                                      cur_r.wdata_y : 32'h0, cur_r.wdata_x};
            end else if (state_r == ST_XFER && cnt_r == '0) begin
                mem_bank_select_n <= '1;
                ext_rd_n          <= 1'b1;
                ext_wr_n          <= 1'b1;
                dram_cycle        <= 1'b0;
                ext_port_data_oe  <= 1'b0;
            end
        end
    end

    // response and completion pulses
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rsp       <= '0;
            core_done <= 1'b0;
            dma_done  <= 1'b0;
        end else begin
            core_done <= 1'b0;
            dma_done  <= 1'b0;
            if (state_r == ST_XFER && cnt_r == '0) begin
                rsp.rdata_x <= ext_port_data_in[31:0];
                rsp.rdata_y <= (sync_r && cur_r.kind == ACC_DATA_SIMD) ?
                               ext_port_data_in[63:32] : 32'h0;
                rsp.fault   <= 1'b0;
            end
            if (state_r == ST_DONE) begin
                core_done <= !cur_dma_r;
                dma_done  <= cur_dma_r;
                if (sel_r == '0) begin
                    rsp <= '{rdata_x: 32'h0, rdata_y: 32'h0, fault: 1'b1};
                end
            end
        end
    end

endmodule // external_port_bank_decoder

// ==== sim/ext_port_properties.sv ====
// checker: decode, timing and arbitration properties of the external port
`timescale 1ns/1ns
module ext_port_properties
    import ext_port_pkg::*;
#(
    parameter int DATA_W = 64
) (
    // clock, reset, configuration
    input wire logic             clk,
    input wire logic             rst_n,
    input wire bank_cfg_t        bank_cfg [NUM_BANK],
    input wire logic [TIME_W-1:0] dram_cas_cycles,
    // masters
    input wire logic             core_valid,
    input wire logic             core_ready,
    input wire ext_req_t         core_req,
    input wire logic             core_done,
    input wire logic             dma_valid,
    input wire logic             dma_ready,
    input wire ext_req_t         dma_req,
    input wire logic             dma_done,
    input wire ext_rsp_t         rsp,
    // memory port
    input wire logic [3:0]       mem_bank_select_n,
    input wire logic [31:0]      ext_addr,
    input wire logic             ext_rd_n,
    input wire logic             ext_wr_n,
    input wire logic             dram_cycle,
    input wire logic [DATA_W-1:0] ext_port_data_out,
    input wire logic             ext_port_data_oe
);
    logic gnt, hit, sy;
    logic [1:0] b;
    logic [31:0] lo, hi, cap;
    ext_req_t g, req_r;
    logic sy_r;
    logic [4:0] cnt_r, lat_r;
    // expected decode of the request being granted
    always_comb begin
        gnt = (core_valid && core_ready) || (dma_valid && dma_ready);
        g = (core_valid && core_ready) ? core_req : dma_req;
        b = g.addr[27:26];
        sy = bank_cfg[b].is_sync;
        lo = (b == 2'h0) ? 32'h0020_0000 : {4'h0, b, 26'h0};
        hi = sy ? {4'h0, b, 26'h3FF_FFFF} : {4'h0, b, 3'h0, 23'h7F_FFFF};
        cap = lo - 32'h1 + (32'h0010_0000 << ((bank_cfg[b].dram_size > 3'h6) ? 3'h6
              : bank_cfg[b].dram_size));
        if (sy && cap < hi) hi = cap;
        hit = g.addr[31:28] == 4'h0 && g.addr >= lo && g.addr <= hi;
        if (g.kind == ACC_FETCH_BASE)
            hit = hit && g.addr >= FETCH_BASE_LO && g.addr <= FETCH_BASE_HI;
        if (g.kind == ACC_FETCH_VAR)
            hit = hit && g.addr >= FETCH_VAR_LO && g.addr <= FETCH_VAR_HI;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 5'h0;
            lat_r <= 5'h0;
            req_r <= '0;
            sy_r <= 1'b0;
        end else if (gnt) begin
            cnt_r <= 5'h1;
            lat_r <= hit ? 5'(4 + (sy ? dram_cas_cycles : bank_cfg[b].wait_cycles)) : 5'h2;
            req_r <= g;
            sy_r <= sy;
        end else begin
            cnt_r <= cnt_r + 5'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_ONE_BANK: assert property ($onehot0(~mem_bank_select_n))
        else $error("more than one bank selected");
    AST_SERIAL: assert property (!(core_ready && dma_ready))
        else $error("both masters granted");
    AST_BUSY_NO_GRANT: assert property (mem_bank_select_n != 4'hF |-> !core_ready && !dma_ready)
        else $error("grant during a memory cycle");
    AST_HIT_SELECT: assert property (gnt && hit |-> ##2
        mem_bank_select_n == ~(4'h1 << req_r.addr[27:26]) && ext_addr == req_r.addr)
        else $error("wrong bank select or address");
    AST_MISS_QUIET: assert property (gnt && !hit |=> mem_bank_select_n == 4'hF
        && ext_rd_n && ext_wr_n ##1 (core_done || dma_done) && rsp.fault)
        else $error("miss started a cycle or lacked fault");
    AST_DONE_LATENCY: assert property (core_done || dma_done |-> cnt_r == lat_r)
        else $error("completion at wrong cycle");
    AST_STROBES: assert property (gnt && hit |-> ##2 dram_cycle == sy_r
        && ext_wr_n == !req_r.write && ext_rd_n == req_r.write)
        else $error("wrong strobe or memory kind");
    AST_SIMD_Y: assert property (gnt && hit && sy && g.write && g.kind == ACC_DATA_SIMD
        |-> ##2 ext_port_data_oe && ext_port_data_out[63:32] == req_r.wdata_y)
        else $error("secondary word missing on upper data");
    AST_DONE_PULSE: assert property (core_done || dma_done |=> !core_done && !dma_done)
        else $error("completion longer than one cycle");
endmodule // ext_port_properties

bind external_port_bank_decoder ext_port_properties #(.DATA_W(DATA_W)) ext_port_properties_inst (
    .clk, .rst_n, .bank_cfg, .dram_cas_cycles, .core_valid, .core_ready, .core_req,
    .core_done, .dma_valid, .dma_ready, .dma_req, .dma_done, .rsp, .mem_bank_select_n,
    .ext_addr, .ext_rd_n, .ext_wr_n, .dram_cycle, .ext_port_data_out, .ext_port_data_oe);

// ==== sim/ext_mem_model.sv ====
// external memory model answering reads on the port data bus
`timescale 1ns/1ns
module ext_mem_model (
    // memory port
    input wire logic        clk,
    input wire logic [3:0]  mem_bank_select_n,
    input wire logic [31:0] ext_addr,
    input wire logic        ext_rd_n,
    output logic [63:0]     ext_port_data_in
);
    initial ext_port_data_in = 64'h0;
    // drives all 64 bits {~ext_addr, ext_addr} while selected for read; released bus toggles every cycle
    always @(posedge clk) begin
        if (mem_bank_select_n != 4'hF && !ext_rd_n)
            ext_port_data_in <= {~ext_addr, ext_addr};
        else
            ext_port_data_in <= ~ext_port_data_in;
    end
endmodule // ext_mem_model

// ==== sim/external_port_bank_decoder_tb.sv ====
// testbench for the external port bank decoder
`timescale 1ns/1ns
module external_port_bank_decoder_tb;
    import ext_port_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, cv = 1'b0, dv = 1'b0;
    logic cr, dr, cd, dd, rd_n, wr_n, dram, oe;
    bank_cfg_t cfg [NUM_BANK];
    logic [TIME_W-1:0] cas = 4'h3;
    ext_req_t creq = '0, dreq = '0;
    ext_rsp_t rsp;
    logic [3:0] sel_n;
    logic [31:0] ea;
    logic [63:0] din, dout;
    int errors = 0, compares = 0;
    external_port_bank_decoder external_port_bank_decoder_inst (
        .clk(clk), .rst_n(rst_n), .bank_cfg(cfg), .dram_cas_cycles(cas),
        .core_valid(cv), .core_ready(cr), .core_req(creq), .core_done(cd),
        .dma_valid(dv), .dma_ready(dr), .dma_req(dreq), .dma_done(dd), .rsp(rsp),
        .mem_bank_select_n(sel_n), .ext_addr(ea), .ext_rd_n(rd_n), .ext_wr_n(wr_n),
        .dram_cycle(dram), .ext_port_data_in(din), .ext_port_data_out(dout),
        .ext_port_data_oe(oe));
    ext_mem_model ext_mem_model_inst (.clk(clk), .mem_bank_select_n(sel_n),
        .ext_addr(ea), .ext_rd_n(rd_n), .ext_port_data_in(din));
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic acc(input bit dma, input logic [31:0] a, input logic wr,
                       input acc_kind_t k, input logic hit);
        int n;
        int m;
        logic sy;
        logic [3:0] w;
        logic [3:0] seen_sel;
        logic [3:0] seen_ctl;
        logic [31:0] seen_a;
        logic [63:0] seen_d;
        @(posedge clk);
        sy = cfg[a[27:26]].is_sync;
        w = sy ? cas : cfg[a[27:26]].wait_cycles;
        seen_sel = 4'hF;
        seen_ctl = 4'h0;
        seen_a = 32'h0;
        seen_d = 64'h0;
        if (dma) dreq <= '{a, wr, k, a, ~a};
        else creq <= '{a, wr, k, a, ~a};
        if (dma) dv <= 1'b1;
        else cv <= 1'b1;
        n = 0;
        do @(negedge clk); while (!(dma ? dr : cr) && ++n < 60);
        @(posedge clk);
        if (dma) dv <= 1'b0;
        else cv <= 1'b0;
        m = 0;
        do begin
            @(negedge clk);
            m++;
            if (sel_n != 4'hF) begin
                seen_sel = sel_n;
                seen_ctl = {rd_n, wr_n, dram, oe};
                seen_a = ea;
                seen_d = dout;
            end
        end while (!(dma ? dd : cd) && m < 60);
        chk(n < 60 && (dma ? dd : cd), 1'b1, "handshake");
        chk(m, hit ? 4 + w : 2, "completion cycles");
        chk(seen_sel, hit ? 4'(~(4'h1 << a[27:26])) : 4'hF, "bank select");
        chk(rsp.fault, !hit, "fault");
        if (hit) chk(seen_a, a, "port address");
        if (hit) chk(seen_ctl, {wr, !wr, sy, wr}, "port controls");
        if (hit && wr) chk(seen_d, {(sy && k == ACC_DATA_SIMD) ? ~a : 32'h0, a}, "write data");
        if (hit && !wr) chk(rsp.rdata_x, a, "read data");
        if (hit && !wr && k == ACC_DATA_SIMD) chk(rsp.rdata_y, 32'(~a), "secondary word");
    endtask
    task automatic set_cfg(input logic [3:0] sync, input logic [2:0] size);
        @(posedge clk);
        for (int i = 0; i < NUM_BANK; i++) cfg[i] <= '{sync[i], size, 4'(i + 2)};
    endtask
    task automatic t_windows(input logic s);
        logic [31:0] lo [4] = '{ASYNC_B0_LO, ASYNC_B1_LO, ASYNC_B2_LO, ASYNC_B3_LO};
        logic [31:0] ah [4] = '{ASYNC_B0_HI, ASYNC_B1_HI, ASYNC_B2_HI, ASYNC_B3_HI};
        logic [31:0] sh [4] = '{SYNC_B0_HI, SYNC_B1_HI, SYNC_B2_HI, SYNC_B3_HI};
        set_cfg({4{s}}, 3'h6);
        acc(0, 32'h001F_FFFF, 0, ACC_DATA, 0);
        for (int i = 0; i < 4; i++) begin
            acc(0, lo[i], 0, ACC_DATA, 1);
            acc(1, s ? sh[i] : ah[i], 1, ACC_DATA, 1);
            acc(0, ah[i] + 32'h1, 0, ACC_DATA, s);
            acc(1, sh[i] + 32'h1, 0, ACC_DATA, i < 3);
        end
        $display("test windows sync=%0d done", s);
    endtask
    task automatic t_dram_size;
        set_cfg(4'h2, 3'h0);
        acc(0, 32'h040F_FFFF, 0, ACC_DATA, 1);
        acc(0, 32'h0410_0000, 0, ACC_DATA, 0);
        @(posedge clk);
        cas <= 4'h6;
        acc(1, 32'h0400_0010, 0, ACC_DATA, 1);
        $display("test dram size done");
    endtask
    task automatic t_simd;
        set_cfg(4'hF, 3'h6);
        acc(0, SYNC_B2_LO, 1, ACC_DATA_SIMD, 1);
        acc(1, SYNC_B2_HI, 0, ACC_DATA_SIMD, 1);
        $display("test simd done");
    endtask
    task automatic t_fetch;
        set_cfg(4'hF, 3'h6);
        acc(0, FETCH_BASE_HI, 0, ACC_FETCH_BASE, 1);
        acc(0, FETCH_VAR_LO, 0, ACC_FETCH_BASE, 0);
        acc(0, FETCH_VAR_LO, 0, ACC_FETCH_VAR, 1);
        acc(1, FETCH_VAR_HI, 0, ACC_FETCH_VAR, 1);
        acc(0, FETCH_VAR_HI + 32'h1, 0, ACC_FETCH_VAR, 0);
        acc(0, SYNC_B1_LO, 0, ACC_FETCH_BASE, 0);
        $display("test fetch done");
    endtask
    task automatic t_arb;
        fork
            acc(0, ASYNC_B1_LO, 0, ACC_DATA, 1);
            acc(1, ASYNC_B3_LO, 0, ACC_DATA, 1);
        join
        $display("test arbitration done");
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < NUM_BANK; i++) cfg[i] = '{1'b0, 3'h6, 4'h2};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_windows(1'b0);
        t_windows(1'b1);
        t_dram_size;
        t_simd;
        t_fetch;
        set_cfg(4'h0, 3'h6);
        t_arb;
        print_verdict;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        print_verdict;
    end
endmodule // external_port_bank_decoder_tb
